// ==== uhc_pkg.sv ====
// Package of shared constants for the host controller mode registers
package uhc_pkg;
  // Command codes: read codes have bit 7 low, write codes bit 7 high
  localparam logic [7:0] CMD_REVISION_RD = 8'h00;
  localparam logic [7:0] CMD_CONTROL_RD = 8'h01;
  localparam logic [7:0] CMD_CONTROL_WR = 8'h81;
  // Field positions of the control register, and the top bit of the revision byte
  localparam int unsigned REMOTE_WAKEUP_ENABLE_BIT = 10;
  localparam int unsigned REMOTE_WAKEUP_CONNECTED_BIT = 9;
  localparam int unsigned FUNCTIONAL_STATE_LSB = 6;
  localparam int unsigned REVISION_MSB = 7;
  // Writable bits and reset value of the control register
  localparam logic [31:0] CONTROL_WRITE_MASK = 32'h0000_06c0;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  // Timing at 100 MHz
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SOF_DELAY_US = 1000;
  localparam int unsigned SOF_DELAY_CYCLES = SOF_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SOFT_RESET_MS = 10;
  localparam int unsigned SOFT_RESET_CYCLES_MAX = SOFT_RESET_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned SOFT_RESET_CYCLES = 16;
  // Functional states; the codes are fixed by the register field encoding
  typedef enum logic [1:0] {
    UHC_STATE_RESET = 2'h0,
    UHC_STATE_RESUME = 2'h1,
    UHC_STATE_OPERATIONAL = 2'h2,
    UHC_STATE_SUSPEND = 2'h3
  } uhc_state_e;
  // Host-side register map of the master's own block
  localparam logic [3:0] HR_CMD = 4'h0;
  localparam logic [3:0] HR_WDATA = 4'h4;
  localparam logic [3:0] HR_RDATA = 4'h8;
  localparam logic [3:0] HR_STATUS = 4'hc;
  localparam logic [3:0] HR_MASK = 4'h0;
  localparam int unsigned ST_DONE_BIT = 0;
  localparam int unsigned ST_WAKE_BIT = 1;
  localparam int unsigned ST_BUSY_BIT = 2;
endpackage : uhc_pkg

// ==== uhc_if.sv ====
// Command link between the host processor end and the controller end
`timescale 1ns/10ps
interface uhc_if;
  logic cmd_valid; // Host presents a command
  logic [7:0] cmd_code; // Command code
  logic [31:0] cmd_wdata; // Write data
  logic cmd_ready; // Device takes the command
  logic rsp_valid; // Read data valid, one cycle
  logic [31:0] rsp_rdata; // Read data
  modport dev (input cmd_valid, input cmd_code, input cmd_wdata,
               output cmd_ready, output rsp_valid, output rsp_rdata);
  modport host (output cmd_valid, output cmd_code, output cmd_wdata,
                input cmd_ready, input rsp_valid, input rsp_rdata);
endinterface : uhc_if

// ==== uhc_dev.sv ====
// Controller end: revision and mode control registers with state logic
`timescale 1ns/10ps
// Summary of operation
// - Revision low byte holds BCD version, fixed
// - Revision read by code 00, never written
// - Control read by 01, written by 81
// - Wakeup enable changes only by driver writes
// - Enable plus resume-detected signals remote wakeup
// - Wakeup enable never gates interrupt generation
// - Wakeup connected cleared by hard reset or a control write, not by soft reset
// - Firmware sets wakeup connected during self test
// - State codes: reset, resume, operational, suspend
// - Frames start 1 ms after entering operational
// - Driver checks start-of-frame flag after entering
// - Hardware changes state only while suspended
// - Suspended plus resume signaling moves to resume
// - Soft reset enters suspend within 10 ms
module uhc_dev #(
  parameter logic [7:0] REVISION = 8'h10, // Arbitrary value
  parameter int unsigned SOF_DELAY = uhc_pkg::SOF_DELAY_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  uhc_if.dev link,
  input wire logic soft_reset_command, // Pulse starting a software reset
  input wire logic resume_signal, // Resume signaling seen on the bus
  input wire logic resume_detected, // Resume-detected status bit
  input wire logic [7:0] irq_events, // Raw interrupt events
  input wire logic [7:0] irq_enable, // Interrupt enables
  output logic irq_out, // Interrupt request
  output logic remote_wakeup, // Wakeup toward the host system
  output logic start_of_frame_flag, // Pulse when frame generation begins
  output logic sof_running, // Frames are being generated
  output logic soft_reset_busy // Software reset in progress
);
  // Control fields held by the controller; reserved bits have no storage at all
  logic wake_en_q; // Remote wakeup enable, written by the driver only
  logic wake_conn_q; // Remote wakeup connected, kept across a software reset
  // Functional state and its one-cycle history
  uhc_pkg::uhc_state_e state_q; // Functional state
  uhc_pkg::uhc_state_e state_prev_q; // State one cycle earlier, to spot an entry
  // Frame start timing
  logic [31:0] sof_cnt_q; // Cycles left before the first frame
  logic sof_wait_q; // Counting towards the first frame
  // Software reset progress
  logic [7:0] srst_cnt_q; // Cycles left of the software reset
  // Command decode
  logic wr_ctrl; // Control write taken in this cycle
  logic rd_any; // Read command of any code taken in this cycle
  logic [31:0] ctrl_view; // Control register as software sees it

  // Commands are taken on every enabled edge. Tying ready to the enable
  // keeps a frozen device from swallowing a command it cannot act on.
  assign link.cmd_ready = clk_en;
  // Control writes are refused while a software reset is still running
  assign wr_ctrl = link.cmd_valid && link.cmd_code == uhc_pkg::CMD_CONTROL_WR
                   && !soft_reset_busy;
  // Read codes have bit 7 low; the answer follows one cycle later
  assign rd_any = link.cmd_valid && !link.cmd_code[7];

  // Control register view; reserved bits are constant zero, so writes to
  // them are dropped without any extra logic
  always_comb begin
    ctrl_view = uhc_pkg::CONTROL_RESET;
    ctrl_view[uhc_pkg::REMOTE_WAKEUP_ENABLE_BIT] = wake_en_q;
    ctrl_view[uhc_pkg::REMOTE_WAKEUP_CONNECTED_BIT] = wake_conn_q;
    ctrl_view[uhc_pkg::FUNCTIONAL_STATE_LSB +: 2] = state_q;
  end

  // Read response. The data word is loaded only by a read, so it stands
  // until the next read, however long the host takes to fetch it.
  // Writes with an unused code, 80 included, fall through and do nothing.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.rsp_valid <= 1'b0;
      link.rsp_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      // One-cycle answer strobe for every read
      link.rsp_valid <= rd_any;
      if (rd_any) begin
        if (link.cmd_code == uhc_pkg::CMD_REVISION_RD) begin
          // Fixed value; no write path reaches it
          link.rsp_rdata <= {24'h00_0000, REVISION};
        end else if (link.cmd_code == uhc_pkg::CMD_CONTROL_RD) begin
          // Live view of the control fields
          link.rsp_rdata <= ctrl_view;
        end else begin
          // Unknown read codes answer zero rather than stale data
          link.rsp_rdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Enable bit. Only a driver write touches it: no state change, soft reset
  // or wakeup event may alter it behind the driver's back.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Hardware reset clears the field
      wake_en_q <= 1'b0;
    end else if (clk_en && wr_ctrl) begin
      // Field copied from the write word
      wake_en_q <= link.cmd_wdata[uhc_pkg::REMOTE_WAKEUP_ENABLE_BIT];
    end
  end

  // Connected bit. Firmware sets it during its self test; a software reset
  // leaves it alone; a hardware reset or a control write can clear it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_conn_q <= 1'b0;
    end else if (clk_en && wr_ctrl) begin
      // Written like any control field by the firmware's write
      wake_conn_q <= link.cmd_wdata[uhc_pkg::REMOTE_WAKEUP_CONNECTED_BIT];
    end
  end

  // Functional state. Priority: software reset, then a driver write, then the
  // one change the controller makes itself, resume detection in suspend.
  // Outside suspend the controller never moves the field on its own.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= uhc_pkg::UHC_STATE_RESET;
      state_prev_q <= uhc_pkg::UHC_STATE_RESET;
    end else if (clk_en) begin
      // Delayed copy feeds the operational entry detector
      state_prev_q <= state_q;
      if (soft_reset_command) begin
        // Software reset parks the controller in suspend
        state_q <= uhc_pkg::UHC_STATE_SUSPEND;
      end else if (wr_ctrl) begin
        // Driver write, any of the four codes
        state_q <= uhc_pkg::uhc_state_e'(link.cmd_wdata[uhc_pkg::FUNCTIONAL_STATE_LSB +: 2]);
      end else if (state_q == uhc_pkg::UHC_STATE_SUSPEND && resume_signal) begin
        // Resume signaling seen while suspended
        state_q <= uhc_pkg::UHC_STATE_RESUME;
      end
    end
  end

  // Software reset sequencer. The sequence length sits far inside the 10 ms
  // bound; control writes are held off until it is done.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srst_cnt_q <= 8'h00;
    end else if (clk_en) begin
      if (soft_reset_command) begin
        // A new pulse restarts the count
        srst_cnt_q <= 8'(uhc_pkg::SOFT_RESET_CYCLES);
      end else if (srst_cnt_q != 8'h00) begin
        // Count down to idle
        srst_cnt_q <= srst_cnt_q - 8'h01;
      end
    end
  end
  // Busy while any count remains
  assign soft_reset_busy = srst_cnt_q != 8'h00;

  // Frame start delay after any entry into operational. The count is loaded
  // one cycle after the state changes and ends one cycle before the flag, so
  // it starts two short and the flag rises SOF_DELAY cycles after the write.
  // SOF_DELAY below 2 is not supported.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sof_cnt_q <= 32'h0000_0000;
      sof_wait_q <= 1'b0;
      sof_running <= 1'b0;
      start_of_frame_flag <= 1'b0;
    end else if (clk_en) begin
      // Flag is a single-cycle pulse
      start_of_frame_flag <= 1'b0;
      if (state_q != uhc_pkg::UHC_STATE_OPERATIONAL) begin
        // Leaving operational stops frames and any pending start
        sof_wait_q <= 1'b0;
        sof_running <= 1'b0;
      end else if (state_prev_q != uhc_pkg::UHC_STATE_OPERATIONAL) begin
        // Fresh entry: arm the delay
        sof_wait_q <= 1'b1;
        sof_cnt_q <= SOF_DELAY - 32'd2;
      end else if (sof_wait_q) begin
        if (sof_cnt_q == 32'h0000_0000) begin
          // Delay over: frames begin and the flag tells the driver
          sof_wait_q <= 1'b0;
          sof_running <= 1'b1;
          start_of_frame_flag <= 1'b1;
        end else begin
          // Count down
          sof_cnt_q <= sof_cnt_q - 32'd1;
        end
      end
    end
  end

  // Wakeup and interrupt outputs. The enable bit only gates the wakeup; the
  // interrupt path does not look at it at all.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Both outputs idle low
      remote_wakeup <= 1'b0;
      irq_out <= 1'b0;
    end else if (clk_en) begin
      // Wakeup needs both the enable and the resume-detected status
      remote_wakeup <= wake_en_q && resume_detected;
      // Any enabled event raises the interrupt
      irq_out <= |(irq_events & irq_enable);
    end
  end
endmodule : uhc_dev

// ==== uhc_host.sv ====
// Host end: AHB-Lite slave registers that issue link commands
`timescale 1ns/10ps
module uhc_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic remote_wakeup,
  output logic irq,
  uhc_if.host link
);
  logic ph_q; // Pending data phase
  logic ph_wr_q;
  logic [3:0] ph_addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [1:0] status_q; // Sticky done and wakeup
  logic [1:0] mask_q;
  logic mask_sel_q;
  logic busy_q; // Command outstanding
  logic rd_pending_q;
  logic [7:0] code_q;
  logic done_ev;
  logic st_rd;

  assign hresp = 1'b0;
  assign hreadyout = 1'b1;
  assign link.cmd_valid = busy_q;
  assign link.cmd_code = code_q;
  assign link.cmd_wdata = wdata_q;
  assign done_ev = (busy_q && link.cmd_ready && code_q[7])
                   || (rd_pending_q && link.rsp_valid);
  assign st_rd = ph_q && !ph_wr_q && ph_addr_q == uhc_pkg::HR_STATUS && !mask_sel_q;

  // Address phase capture; offset 0x10 selects the mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      ph_wr_q <= 1'b0;
      ph_addr_q <= 4'h0;
      mask_sel_q <= 1'b0;
    end else if (clk_en) begin
      ph_q <= hsel && hready && htrans[1];
      ph_wr_q <= hwrite;
      ph_addr_q <= haddr[3:0];
      mask_sel_q <= haddr[4];
    end
  end

  // Register writes and command launch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdata_q <= 32'h0000_0000;
      code_q <= 8'h00;
      busy_q <= 1'b0;
      rd_pending_q <= 1'b0;
      mask_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (busy_q && link.cmd_ready) begin
        busy_q <= 1'b0;
        rd_pending_q <= !code_q[7];
      end
      if (rd_pending_q && link.rsp_valid) begin
        rd_pending_q <= 1'b0;
        rdata_q <= link.rsp_rdata;
      end
      if (ph_q && ph_wr_q) begin
        if (mask_sel_q) begin
          mask_q <= hwdata[1:0];
        end else if (ph_addr_q == uhc_pkg::HR_WDATA) begin
          wdata_q <= hwdata;
        end else if (ph_addr_q == uhc_pkg::HR_CMD && !busy_q && !rd_pending_q) begin
          code_q <= hwdata[7:0];
          busy_q <= 1'b1;
        end
      end
    end
  end

  // Sticky status, cleared by a status read; a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 2'h0;
    end else if (clk_en) begin
      status_q <= (st_rd ? 2'h0 : status_q) | {remote_wakeup, done_ev};
    end
  end
  assign irq = |(status_q & mask_q);

  // Read data mux
  always_comb begin
    hrdata = 32'h0000_0000;
    if (mask_sel_q) begin
      hrdata[1:0] = mask_q;
    end else if (ph_addr_q == uhc_pkg::HR_RDATA) begin
      hrdata = rdata_q;
    end else if (ph_addr_q == uhc_pkg::HR_WDATA) begin
      hrdata = wdata_q;
    end else if (ph_addr_q == uhc_pkg::HR_STATUS) begin
      hrdata[1:0] = status_q;
      hrdata[uhc_pkg::ST_BUSY_BIT] = busy_q | rd_pending_q;
    end else begin
      hrdata[7:0] = code_q;
    end
  end
endmodule : uhc_host

// ==== uhc_chk.sv ====
// Checker of the command link between the host end and the controller end
`timescale 1ns/10ps
module uhc_chk #(
  parameter logic [7:0] REVISION = 8'h10 // Arbitrary value, must match the device
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_wdata,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // A read command followed by its answer
  sequence s_rd(logic [7:0] c);
    cmd_valid && cmd_code == c ##1 rsp_valid;
  endsequence
  // Read commands have bit 7 low
  sequence s_any_rd;
    cmd_valid && !cmd_code[7];
  endsequence
  // Host presents one command at a time and drops it once taken
  property p_ready; cmd_valid && cmd_ready |=> !cmd_valid; endproperty
  a_ready: assert property (p_ready) else $error("command held after take");
  property p_rev; s_rd(uhc_pkg::CMD_REVISION_RD) |-> rsp_rdata == {24'h0, REVISION}; endproperty
  a_rev: assert property (p_rev) else $error("revision word wrong");
  property p_ctrl;
    s_rd(uhc_pkg::CMD_CONTROL_RD) |-> (rsp_rdata & ~uhc_pkg::CONTROL_WRITE_MASK) == 32'h0;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("reserved control bits set");
  property p_rd_answer; s_any_rd |=> rsp_valid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_unknown;
    cmd_valid && !cmd_code[7] && cmd_code > 8'h01 |=> rsp_rdata == 32'h0;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown code not zero");
  property p_wr_silent; cmd_valid && cmd_code[7] |=> !rsp_valid; endproperty
  a_wr_silent: assert property (p_wr_silent) else $error("write answered");
  property p_cause; rsp_valid |-> $past(cmd_valid && !cmd_code[7]); endproperty
  a_cause: assert property (p_cause) else $error("answer without read");
  property p_pulse; rsp_valid && !cmd_valid |=> !rsp_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("answer too long");
  property p_hold; !(cmd_valid && !cmd_code[7]) |=> $stable(rsp_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule : uhc_chk

// ==== usb_host_ctrl_mode_regs_test.sv ====
// Testbench joining host end and controller end over the command link
`timescale 1ns/10ps
module usb_host_ctrl_mode_regs_test;
  localparam logic [7:0] REV = 8'h10; // Arbitrary revision value
  localparam int SOF = 10; // Shortened frame start delay keeps the run brief
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, irq, remote_wakeup, irq_out, start_of_frame_flag;
  logic sof_running, soft_reset_busy;
  logic soft_reset_command = 1'b0, resume_signal = 1'b0, resume_detected = 1'b0;
  logic [7:0] irq_events = 8'h0, irq_enable = 8'h0;
  int err_total = 0, checked = 0, cyc = 0, t_take = 0, t_sof = 0;
  uhc_if uhc_if_i ();
  always #5 hclk = ~hclk;
  uhc_host uhc_host_i (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .remote_wakeup(remote_wakeup), .irq(irq), .link(uhc_if_i));
  uhc_dev #(.REVISION(REV), .SOF_DELAY(SOF)) uhc_dev_i (.hclk(hclk), .hresetn(hresetn),
    .clk_en(1'b1), .link(uhc_if_i), .soft_reset_command(soft_reset_command),
    .resume_signal(resume_signal), .resume_detected(resume_detected),
    .irq_events(irq_events), .irq_enable(irq_enable), .irq_out(irq_out),
    .remote_wakeup(remote_wakeup), .start_of_frame_flag(start_of_frame_flag),
    .sof_running(sof_running), .soft_reset_busy(soft_reset_busy));
  uhc_chk #(.REVISION(REV)) uhc_chk_i (.hclk(hclk), .hresetn(hresetn),
    .cmd_valid(uhc_if_i.cmd_valid), .cmd_code(uhc_if_i.cmd_code),
    .cmd_wdata(uhc_if_i.cmd_wdata), .cmd_ready(uhc_if_i.cmd_ready),
    .rsp_valid(uhc_if_i.rsp_valid), .rsp_rdata(uhc_if_i.rsp_rdata));
  // Cycle count, moments of the operational write and frame start, and the hang limit
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (uhc_if_i.cmd_valid && uhc_if_i.cmd_code == 8'h81 && uhc_if_i.cmd_wdata[7:6] == 2'h2)
      t_take <= cyc;
    if (start_of_frame_flag === 1'b1)
      t_sof <= cyc;
    if (cyc == 6000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk1
  // One single-word bus transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // Link command through the host registers; polling bounded so a dead link is seen
  task automatic cmd(input logic [7:0] code, input logic [31:0] d);
    int n;
    n = 0;
    ahb(1'b1, 32'h4, d);
    ahb(1'b1, 32'h0, {24'h0, code});
    do begin
      ahb(1'b0, 32'hc, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 20);
    chk1(rd[0], 1'b1);
    chk1(hresp, 1'b0);
    ahb(1'b0, 32'h8, 32'h0);
  endtask : cmd
  task automatic t_rev;
    cmd(8'h00, 32'h0);
    chk32(rd, {24'h0, REV});
    cmd(8'h80, 32'hffff_ffff);
    cmd(8'h00, 32'h0);
    chk32(rd, {24'h0, REV});
    cmd(8'h7f, 32'h0);
    chk32(rd, 32'h0);
  endtask : t_rev
  // Every state code written with reserved bits set, read back clean
  task automatic t_ctrl;
    cmd(8'h01, 32'h0);
    chk32(rd, 32'h0);
    for (int s = 0; s < 4; s++) begin
      cmd(8'h81, 32'hffff_ff3f | (32'(s) << 6));
      cmd(8'h01, 32'h0);
      chk32(rd, 32'h0000_0600 | (32'(s) << 6));
    end
    cmd(8'h81, 32'h0000_0080);
    repeat (3 * SOF) @(posedge hclk);
    chk1(t_sof - t_take >= SOF && t_sof - t_take <= SOF + 2, 1'b1);
    chk1(sof_running, 1'b1);
  endtask : t_ctrl
  // Wakeup follows enable and resume status; interrupt raised, masked, cleared
  task automatic t_wake;
    ahb(1'b1, 32'h10, 32'h0);
    cmd(8'h81, 32'h0000_0400);
    irq_events <= 8'h01;
    irq_enable <= 8'h01;
    resume_detected <= 1'b1;
    repeat (3) @(posedge hclk);
    chk1(remote_wakeup, 1'b1);
    chk1(irq_out, 1'b1);
    chk1(irq, 1'b0);
    ahb(1'b1, 32'h10, 32'h2);
    // Mask lands at the data-phase edge; look one edge later
    @(posedge hclk);
    chk1(irq, 1'b1);
    resume_detected <= 1'b0;
    cmd(8'h81, 32'h0);
    resume_detected <= 1'b1;
    repeat (3) @(posedge hclk);
    chk1(remote_wakeup, 1'b0);
    chk1(irq_out, 1'b1);
    chk1(irq, 1'b0);
    irq_events <= 8'h02;
    repeat (2) @(posedge hclk);
    chk1(irq_out, 1'b0);
    resume_detected <= 1'b0;
  endtask : t_wake
  // Soft reset to suspend, then resume only while suspended
  task automatic t_soft;
    int n;
    n = 0;
    cmd(8'h81, 32'h0000_0680);
    soft_reset_command <= 1'b1;
    @(posedge hclk);
    soft_reset_command <= 1'b0;
    repeat (2) @(posedge hclk);
    while (soft_reset_busy !== 1'b0 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    chk1(soft_reset_busy, 1'b0);
    cmd(8'h01, 32'h0);
    chk32(rd & 32'h0000_02c0, 32'h0000_02c0);
    cmd(8'h81, 32'h0000_06c0);
    for (int k = 0; k < 2; k++) begin
      resume_signal <= 1'b1;
      repeat (2) @(posedge hclk);
      resume_signal <= 1'b0;
      cmd(8'h01, 32'h0);
      chk32(rd, k == 0 ? 32'h0000_0640 : 32'h0000_0680);
      if (k == 0)
        cmd(8'h81, 32'h0000_0680);
    end
  endtask : t_soft
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // Main sequence, with a second hard reset that must clear the connected bit
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_rev();
    t_ctrl();
    t_wake();
    t_soft();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    cmd(8'h01, 32'h0);
    chk32(rd, 32'h0);
    wrap_up();
  end
endmodule : usb_host_ctrl_mode_regs_test
